// File: hw/ghb_pkg.sv
// constants, field positions, reset values and the state type of the generic host port
// assumes a single 125 MHz clock and an APB register slave
package ghb_pkg;

   // ************************************************************
   // widths of the host pins
   // ************************************************************
   localparam int ADDR_W      = 21;             // host address pins, 2M byte buffer space
   localparam int DATA_W      = 16;             // host data pins
   localparam int STRAP_W     = 16;             // memory data pins read as straps
   localparam int REG_SPAN    = 64;             // bytes decoded in the register region
   localparam int REG_IDX_W   = $clog2(REG_SPAN) - 1;   // halfword index
   localparam int BUF_SPAN_W  = 21;             // display buffer decode width, 2M bytes
   localparam int SYNC_W      = STRAP_W + 1 + 1 + 1 + 4 + ADDR_W + DATA_W;

   // ************************************************************
   // strap field positions and codes
   // ************************************************************
   localparam int STRAP_WIDTH_BIT   = 0;        // high selects the 8-bit host bus
   localparam int STRAP_TYPE_LSB    = 1;        // three bus type bits
   localparam int STRAP_ENDIAN_BIT  = 4;        // high selects little endian
   localparam int STRAP_WAITPOL_BIT = 5;        // high makes hold-off active high
   localparam logic [2:0] BUS_TYPE_GENERIC = 3'h3;
   localparam logic [1:0] STRAP_SETTLE     = 2'h2;   // edges after release before capture

   // ************************************************************
   // register offsets, fields and reset values
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STRAP  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_COUNT  = 8'h0c;
   localparam int CTRL_PRIO_BIT   = 0;          // host wins over display fetch
   localparam int CTRL_EN_BIT     = 1;          // host port enabled
   localparam int STAT_BS_BIT     = 0;          // bus start pin seen low
   localparam int STAT_MODE_BIT   = 1;          // access while not in generic mode
   localparam int STAT_BUSY_BIT   = 2;          // host cycle in progress
   localparam int STRAPREG_GEN_BIT  = 16;       // generic mode active
   localparam int STRAPREG_DONE_BIT = 17;       // straps captured
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam logic       HOLD_RESET = 1'b0;
   // idle levels of the synchronised pins: strobes, chip select and bus start high
   localparam logic [SYNC_W-1:0] SYNC_IDLE = {16'h0000, 1'h1, 1'h1, 1'h0, 4'hf,
                                              21'h000000, 16'h0000};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARB  = 3'b001,
      ST_REG  = 3'b010,
      ST_CAP  = 3'b011,
      ST_BUF  = 3'b100,
      ST_DONE = 3'b101
   } ghb_state_t;

endpackage : ghb_pkg

// File: hw/ghb_ram_if.sv
// carrier between the host port and its register file
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ghb_ram_if #(parameter int AW = 5, parameter int DW = 16);
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [1:0]    be;
   logic [DW-1:0] rdata;
   modport ctrl (output en, we, addr, wdata, be, input rdata);
   modport ram  (input en, we, addr, wdata, be, output rdata);
endinterface : ghb_ram_if

// File: hw/ghb_sync.sv
// two-stage synchroniser for a vector of pins
// assumes each bit is a level that is stable for more than one clock
`timescale 1ns/1ps
module ghb_sync #(
   parameter int               WIDTH    = 1,
   parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_r;

   if (WIDTH < 1) begin : g_bad_width
      $error("ghb_sync needs a width of at least one");
   end

   // ************************************************************
   // first stage feeds only the second
   // ************************************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r  <= IDLE_VAL;
         syncOut <= IDLE_VAL;
      end else begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule : ghb_sync

// File: hw/ghb_reg_ram.sv
// register file of the host port, halfwords with byte enables
// assumes one access per enabled cycle; read data is registered
`timescale 1ns/1ps
module ghb_reg_ram #(
   parameter int AW = 5
) (
   input wire logic clock,
   ghb_ram_if.ram   port
);
   logic [15:0] mem [2**AW];

   if (AW < 1) begin : g_bad_aw
      $error("ghb_reg_ram needs at least one address bit");
   end

   // ************************************************************
   // byte-wise write, registered read
   // ************************************************************
   always_ff @(posedge clock) begin
      if (port.en && port.we && port.be[0]) begin
         mem[port.addr][7:0] <= port.wdata[7:0];
      end
      if (port.en && port.we && port.be[1]) begin
         mem[port.addr][15:8] <= port.wdata[15:8];
      end
      if (port.en) begin
         port.rdata <= mem[port.addr];
      end
   end
endmodule : ghb_reg_ram

// File: hw/ghb_host_port.sv
// generic host bus port: strap capture, address decode, byte strobes, hold-off
// assumes asynchronous host pins, a same-clock display buffer port and an APB master
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps

module ghb_host_port
   import ghb_pkg::*;
#(
   parameter int APB_AW = 8
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [STRAP_W-1:0] memDataIn,
   input  wire logic              hostCsN,
   input  wire logic              memRegSel,
   input  wire logic [ADDR_W-1:0] hostAddr,
   input  wire logic [DATA_W-1:0] hostDataIn,
   output logic      [DATA_W-1:0] hostDataOut,
   output logic                   hostDataOe,
   input  wire logic              lowByteReadN,
   input  wire logic              highByteReadN,
   input  wire logic              lowByteWriteN,
   input  wire logic              highByteWriteN,
   input  wire logic              busStartPin,
   output logic                   holdOff,
   input  wire logic              dispReq,
   output logic                   dispGnt,
   output logic                   bufReq,
   output logic                   bufWe,
   output logic [BUF_SPAN_W-1:0]  bufAddr,
   output logic [DATA_W-1:0]      bufWdata,
   output logic [1:0]             bufBe,
   input  wire logic              bufAck,
   input  wire logic [DATA_W-1:0] bufRdata
);

   if (APB_AW < 8) begin : g_bad_aw
      $error("ghb_host_port needs at least eight APB address bits");
   end

   // ************************************************************
   // helpers
   // ************************************************************
   // byte lanes touched by a cycle
   function automatic logic [1:0] laneMask(input logic w8, input logic a0,
                                           input logic lo, input logic hi);
      if (w8) begin
         laneMask = a0 ? 2'h2 : 2'h1;
      end else begin
         laneMask = {hi, lo};
      end
   endfunction : laneMask

   // host data into core order
   function automatic logic [15:0] toCore(input logic w8, input logic big,
                                          input logic [15:0] d);
      if (w8) begin
         toCore = {d[7:0], d[7:0]};
      end else if (big) begin
         toCore = {d[7:0], d[15:8]};
      end else begin
         toCore = d;
      end
   endfunction : toCore

   // core data into host order
   function automatic logic [15:0] toHost(input logic w8, input logic big,
                                          input logic a0, input logic [15:0] d);
      if (w8) begin
         toHost = {8'h00, (a0 ? d[15:8] : d[7:0])};
      end else if (big) begin
         toHost = {d[7:0], d[15:8]};
      end else begin
         toHost = d;
      end
   endfunction : toHost

   // ************************************************************
   // pin synchronisation
   // ************************************************************
   logic [SYNC_W-1:0]  syncPins;
   logic [STRAP_W-1:0] strapS;
   logic               bsS;
   logic               csS;
   logic               selS;
   logic               loRdS;
   logic               hiRdS;
   logic               loWrS;
   logic               hiWrS;
   logic [ADDR_W-1:0]  addrS;
   logic [DATA_W-1:0]  dataS;

   ghb_sync #(.WIDTH(SYNC_W), .IDLE_VAL(SYNC_IDLE)) u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .asyncIn ({memDataIn, busStartPin, hostCsN, memRegSel, lowByteReadN,
                 highByteReadN, lowByteWriteN, highByteWriteN, hostAddr, hostDataIn}),
      .syncOut (syncPins)
   );

   assign {strapS, bsS, csS, selS, loRdS, hiRdS, loWrS, hiWrS, addrS, dataS} = syncPins;

   // ************************************************************
   // strap capture
   // ************************************************************
   logic [STRAP_W-1:0] strapVal_r;
   logic [1:0]         strapCnt_r;
   logic               strapDone_r;

   // straps caught once after release, then frozen until the next reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         strapVal_r  <= '0;
         strapCnt_r  <= 2'h0;
         strapDone_r <= 1'b0;
      end else if (!strapDone_r) begin
         if (strapCnt_r == STRAP_SETTLE) begin
            strapVal_r  <= strapS;
            strapDone_r <= 1'b1;
         end else begin
            strapCnt_r <= strapCnt_r + 2'h1;
         end
      end
   end

   wire busWidth8   = strapVal_r[STRAP_WIDTH_BIT];
   wire genericMode = strapVal_r[STRAP_TYPE_LSB +: 3] == BUS_TYPE_GENERIC;
   wire bigEndian   = ~strapVal_r[STRAP_ENDIAN_BIT];
   wire waitHigh    = strapVal_r[STRAP_WAITPOL_BIT];

   // ************************************************************
   // host cycle decode
   // ************************************************************
   logic [1:0] ctrl_r;
   wire loAct     = ~loRdS | ~loWrS;
   wire hiAct     = ~hiRdS | ~hiWrS;
   wire isReadS   = ~loRdS | ~hiRdS;
   wire strobeAny = ~csS & (loAct | hiAct);
   wire hostGo    = strapDone_r & genericMode & ctrl_r[CTRL_EN_BIT] & strobeAny;
   wire hostPri   = ctrl_r[CTRL_PRIO_BIT];
   wire [1:0]  laneS  = laneMask(busWidth8, addrS[0], loAct, hiAct);
   wire [15:0] wdataS = toCore(busWidth8, bigEndian, dataS);

   // ************************************************************
   // cycle sequencer
   // ************************************************************
   ghb_state_t state_r;
   ghb_state_t stateNxt;
   logic       finish;
   logic       release_;

   // display fetch holds the buffer until it lets go or the host has priority
   always_comb begin
      stateNxt = state_r;
      finish   = 1'b0;
      release_ = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (hostGo) stateNxt = ST_ARB;
         end
         ST_ARB: begin
            if (!selS) begin
               stateNxt = ST_REG;
            end else if (!dispReq || hostPri) begin
               stateNxt = ST_BUF;
            end
         end
         ST_REG: begin
            stateNxt = ST_CAP;
         end
         ST_CAP: begin
            finish   = 1'b1;
            stateNxt = ST_DONE;
         end
         ST_BUF: begin
            if (bufAck) begin
               finish   = 1'b1;
               stateNxt = ST_DONE;
            end
         end
         ST_DONE: begin
            if (!strobeAny) begin
               release_ = 1'b1;
               stateNxt = ST_IDLE;
            end
         end
         default: stateNxt = ST_IDLE;
      endcase
   end

   ghb_ram_if #(.AW(REG_IDX_W), .DW(DATA_W)) ramIf ();   // carrier to the register file
   logic [ADDR_W-1:0] cycAddr_r;
   logic              cycRead_r;
   logic [1:0]        cycBe_r;
   logic [15:0]       cycWdata_r;
   logic              hostReady_r;
   wire               readyNxt = finish | (hostReady_r & ~release_);
   wire [15:0]        rawRd    = (state_r == ST_CAP) ? ramIf.rdata : bufRdata;
   wire               toBuf    = (state_r == ST_ARB) && (stateNxt == ST_BUF);

   // state, cycle latch and ready
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         cycAddr_r   <= '0;
         cycRead_r   <= 1'b0;
         cycBe_r     <= 2'h0;
         cycWdata_r  <= 16'h0000;
         hostReady_r <= 1'b0;
      end else begin
         state_r     <= stateNxt;
         hostReady_r <= readyNxt;
         if (state_r == ST_ARB) begin
            cycAddr_r  <= addrS;
            cycRead_r  <= isReadS;
            cycBe_r    <= laneS;
            cycWdata_r <= wdataS;
         end
      end
   end

   // hold-off follows the strapped polarity
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         holdOff <= HOLD_RESET;
      end else if (strapDone_r) begin
         holdOff <= waitHigh ? ~readyNxt : readyNxt;
      end
   end

   // read data driven from the finish until the strobes drop
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hostDataOut <= 16'h0000;
         hostDataOe  <= 1'b0;
      end else if (finish && cycRead_r) begin
         hostDataOut <= toHost(busWidth8, bigEndian, cycAddr_r[0], rawRd);
         hostDataOe  <= 1'b1;
      end else if (release_) begin
         hostDataOe  <= 1'b0;
      end
   end

   // ************************************************************
   // register file and display buffer port
   // ************************************************************

   assign ramIf.en    = state_r == ST_REG;
   assign ramIf.we    = ~cycRead_r;
   assign ramIf.addr  = cycAddr_r[REG_IDX_W:1];
   assign ramIf.be    = cycBe_r;
   assign ramIf.wdata = cycWdata_r;

   ghb_reg_ram #(.AW(REG_IDX_W)) u_regs (
      .clock (clock),
      .port  (ramIf)
   );

   // buffer request held until acknowledged
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bufReq   <= 1'b0;
         bufWe    <= 1'b0;
         bufAddr  <= '0;
         bufWdata <= 16'h0000;
         bufBe    <= 2'h0;
         dispGnt  <= 1'b0;
      end else begin
         bufReq  <= stateNxt == ST_BUF;
         dispGnt <= dispReq & (stateNxt != ST_BUF);
         if (toBuf) begin
            bufAddr  <= addrS[BUF_SPAN_W-1:0];
            bufWe    <= ~isReadS;
            bufWdata <= wdataS;
            bufBe    <= laneS;
         end
      end
   end

   // ************************************************************
   // APB registers
   // ************************************************************
   logic        bsErr_r;
   logic        modeErr_r;
   logic [15:0] accessCnt_r;
   wire [7:0] ofs     = paddr[7:0];
   wire hitCtrl       = ofs == OFS_CTRL;
   wire hitStrap      = ofs == OFS_STRAP;
   wire hitStatus     = ofs == OFS_STATUS;
   wire hitCount      = ofs == OFS_COUNT;
   wire mapped        = hitCtrl | hitStrap | hitStatus | hitCount;
   wire apbSetup      = psel & ~penable;
   wire apbWr         = psel & penable & pready & pwrite & mapped;
   wire bsSet         = strapDone_r & genericMode & ~bsS;
   wire modeSet       = strapDone_r & ~genericMode & strobeAny;
   wire [31:0] rdMux  = hitCtrl   ? {30'h0, ctrl_r} :
                        hitStrap  ? {14'h0, strapDone_r, genericMode, strapVal_r} :
                        hitStatus ? {29'h0, state_r != ST_IDLE, modeErr_r, bsErr_r} :
                        hitCount  ? {16'h0, accessCnt_r} : 32'h0;

   // one wait-free access phase; errors flagged on unmapped offsets
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbSetup;
         pslverr <= apbSetup & ~mapped;
         if (apbSetup) prdata <= rdMux;
      end
   end

   // control, sticky flags with set over clear, access counter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r      <= CTRL_RESET;
         bsErr_r     <= 1'b0;
         modeErr_r   <= 1'b0;
         accessCnt_r <= 16'h0000;
      end else begin
         if (apbWr && hitCtrl) ctrl_r <= pwdata[1:0];
         bsErr_r   <= bsSet | (bsErr_r & ~(apbWr & hitStatus & pwdata[STAT_BS_BIT]));
         modeErr_r <= modeSet | (modeErr_r & ~(apbWr & hitStatus & pwdata[STAT_MODE_BIT]));
         if (finish) accessCnt_r <= accessCnt_r + 16'h0001;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire rawGo = ~hostCsN & ~(lowByteReadN & highByteReadN & lowByteWriteN & highByteWriteN);

   property p_strapCapture;
      $rose(strapDone_r) |-> strapVal_r == $past(strapS);
   endproperty
   a_strapCapture: assert property (p_strapCapture) else $error("straps not captured");
   property p_strapFrozen;
      strapDone_r |=> $stable(strapVal_r) && strapDone_r;
   endproperty
   a_strapFrozen: assert property (p_strapFrozen) else $error("straps changed");
   property p_narrowRead;
      $rose(hostDataOe) && busWidth8 |-> hostDataOut[15:8] == 8'h00;
   endproperty
   a_narrowRead: assert property (p_narrowRead) else $error("8-bit read used high lane");
   property p_otherMode;
      strapDone_r && !genericMode && state_r == ST_IDLE |=> state_r == ST_IDLE;
   endproperty
   a_otherMode: assert property (p_otherMode) else $error("cycle outside generic mode");
   property p_bigSwap;
      $rose(hostReady_r) && cycRead_r && bigEndian && !busWidth8
         |-> hostDataOut == {$past(rawRd[7:0]), $past(rawRd[15:8])};
   endproperty
   a_bigSwap: assert property (p_bigSwap) else $error("big endian lanes wrong");
   property p_waitPol;
      strapDone_r && $past(strapDone_r) |-> holdOff == (waitHigh ^ hostReady_r);
   endproperty
   a_waitPol: assert property (p_waitPol) else $error("hold-off polarity wrong");
   property p_busStart;
      strapDone_r && genericMode && !bsS |=> bsErr_r;
   endproperty
   a_busStart: assert property (p_busStart) else $error("bus start low not flagged");
   property p_regAlias;
      state_r == ST_ARB && !selS |=> state_r == ST_REG && ramIf.addr == $past(addrS[5:1]);
   endproperty
   a_regAlias: assert property (p_regAlias) else $error("register index wrong");
   property p_bufAlias;
      $rose(bufReq) |-> bufAddr == $past(addrS) && $past(selS);
   endproperty
   a_bufAlias: assert property (p_bufAlias) else $error("buffer address wrong");
   property p_syncDelay;
      (state_r == ST_IDLE) ##1 (state_r == ST_ARB) |-> $past(rawGo, 3);
   endproperty
   a_syncDelay: assert property (p_syncDelay) else $error("strobe used before sync");
   property p_arbHold;
      state_r == ST_ARB && selS && dispReq && !hostPri
         |=> state_r == ST_ARB && !hostReady_r && !bufReq;
   endproperty
   a_arbHold: assert property (p_arbHold) else $error("host passed arbitration");
   property p_holdDuringBuf;
      bufReq |-> !hostReady_r && holdOff == waitHigh;
   endproperty
   a_holdDuringBuf: assert property (p_holdDuringBuf) else $error("hold-off released early");

endmodule : ghb_host_port

// File: bench/ghb_glue_model.sv
// glue between processor strobes and the byte strobes of the host port
// assumes the processor holds address and strobes for a whole cycle
`timescale 1ns/1ps
module ghb_glue_model (
   input  wire logic [31:0] cpuAddr,
   input  wire logic        cpuRdN,
   input  wire logic        cpuWrN,
   input  wire logic        cpuShbN,
   output logic             csN,
   output logic             memRegSel,
   output logic [20:0]      hostAddr,
   output logic             lowByteReadN,
   output logic             highByteReadN,
   output logic             lowByteWriteN,
   output logic             highByteWriteN,
   output logic             busStartPin
);
   // window decode and lane selection, nothing outside the window
   wire logic sel = cpuAddr[31:24] == 8'h0a;
   wire logic lo  = sel & !cpuAddr[0];
   wire logic hi  = sel & !cpuShbN;
   assign csN            = !(sel & !(cpuRdN & cpuWrN));
   assign memRegSel      = cpuAddr[21];
   assign hostAddr       = cpuAddr[20:0];
   assign lowByteReadN   = !(lo & !cpuRdN);
   assign highByteReadN  = !(hi & !cpuRdN);
   assign lowByteWriteN  = !(lo & !cpuWrN);
   assign highByteWriteN = !(hi & !cpuWrN);
   assign busStartPin    = 1'b1;
endmodule : ghb_glue_model

// File: bench/generic_host_bus_glue_test.sv
// self-checking bench: straps, apb registers, host register and buffer cycles
// assumes the glue model on the host pins and a one-cycle buffer acknowledge
`timescale 1ns/1ps
module generic_host_bus_glue_test
   import ghb_pkg::*;
;
   logic        clock, pready, pslverr, e, holdOff, hostDataOe, bufReq, bufWe, g, bWe, rp;
   logic        csN, mrs, bsp, lbr, hbr, lbw, hbw;
   logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        cpuRdN = 1'b1, cpuWrN = 1'b1, cpuShbN = 1'b1, bufAck = 1'b0, dispReq = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, cpuAddr = 32'h0, prdata, q;
   logic [15:0] hostData = 16'h0, rv = 16'h4e9c, hostDataOut, bufWdata, r, t, bWd;
   logic [15:0] strap = 16'h0036;
   wire         w8 = strap[STRAP_WIDTH_BIT], wp = strap[STRAP_WAITPOL_BIT];
   wire         big = !strap[STRAP_ENDIAN_BIT] & !w8;
   logic [20:0] hostAddr, bufAddr, bAddr;
   logic [1:0]  bufBe, bBe;
   logic [15:0] regs [32];
   int          mismatches = 0, checks = 0, n, p;
   ghb_host_port ghb_host_port_inst (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .memDataIn(strap), .hostCsN(csN),
      .memRegSel(mrs), .hostAddr(hostAddr), .hostDataIn(hostData), .hostDataOut(hostDataOut),
      .hostDataOe(hostDataOe), .lowByteReadN(lbr), .highByteReadN(hbr), .lowByteWriteN(lbw),
      .highByteWriteN(hbw), .busStartPin(bsp), .holdOff(holdOff), .dispReq(dispReq),
      .dispGnt(g), .bufReq(bufReq), .bufWe(bufWe), .bufAddr(bufAddr), .bufWdata(bufWdata),
      .bufBe(bufBe), .bufAck(bufAck), .bufRdata(16'h5aa5));
   ghb_glue_model ghb_glue_model_inst (.cpuAddr(cpuAddr), .cpuRdN(cpuRdN), .cpuWrN(cpuWrN),
      .cpuShbN(cpuShbN), .csN(csN), .memRegSel(mrs), .hostAddr(hostAddr),
      .lowByteReadN(lbr), .highByteReadN(hbr), .lowByteWriteN(lbw),
      .highByteWriteN(hbw), .busStartPin(bsp));
   // clock, display fetch toggling and a one-cycle buffer acknowledge
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      dispReq <= ~dispReq;
      bufAck  <= bufReq & !bufAck;
      rp      <= rst_n;
      if (rp && rst_n) chk(32'(g), 32'(!dispReq & !bufReq));
      if (bufReq & !bufAck) begin
         bAddr = bufAddr;
         bBe   = bufBe;
         bWd   = bufWdata;
         bWe   = bufWe;
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic tmo(input int k);
      if (k >= 200) begin
         mismatches++;
         close_out();
      end
   endtask : tmo
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 200);
      tmo(k);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic waitHold(input logic lvl);
      int k;
      for (k = 0; k < 200 && holdOff !== lvl; k++) @(posedge clock);
      tmo(k);
   endtask : waitHold
   // one host cycle through the glue, checked against the register model or the captured buffer request and fixed buffer data
   task automatic acc(input logic [31:0] a, input logic w, input logic shbN);
      logic [4:0]  i;
      logic [15:0] d, c, x;
      i  = a[5:1];
      rv = lfsr(rv);
      d  = w8 ? {2{rv[7:0]}} : rv;
      c  = big ? {d[7:0], d[15:8]} : d;
      @(posedge clock);
      cpuAddr  <= a;
      cpuShbN  <= shbN;
      hostData <= d;
      cpuRdN   <= w;
      cpuWrN   <= !w;
      waitHold(!wp);
      r = hostDataOut;
      chk(32'(hostDataOe), 32'(!w));
      cpuRdN   <= 1'b1;
      cpuWrN   <= 1'b1;
      hostData <= ~d;
      waitHold(wp);
      chk(32'(hostDataOe), 32'h0);
      x = a[21] ? 16'h5aa5 : regs[i];
      if (a[21]) chk({bBe, 8'h0, bWe, bAddr}, {!shbN, !a[0], 8'h0, w, a[20:0]});
      if (a[21] && w) chk(32'(bWd), 32'(c));
      if (!a[0] && w && !a[21]) regs[i][7:0] = c[7:0];
      if (!shbN && w && !a[21]) regs[i][15:8] = c[15:8];
      if (w8) x = {8'h00, a[0] ? x[15:8] : x[7:0]};
      else if (big) r = {r[7:0], r[15:8]};
      if ((!a[0] || w8) && !w) chk(32'(r[7:0]), 32'(x[7:0]));
      if ((!shbN || w8) && !w) chk(32'(r[15:8]), 32'(x[15:8]));
   endtask : acc
   initial begin
      // three strap sets: 16-bit little, 8-bit with low wait, 16-bit big
      for (p = 0; p < 3; p++) begin
         rst_n <= 1'b0;
         strap <= p == 0 ? 16'h0036 : p == 1 ? 16'h0007 : 16'h0026;
         repeat (20) @(posedge clock);
         rst_n <= 1'b1;
         repeat (6) @(posedge clock);
         chk(32'(holdOff), 32'(wp));
         apb(1'b0, OFS_STRAP, 32'h0);
         chk(q, {14'h0, 2'h3, strap});
         apb(1'b0, 8'h10, 32'h0);
         chk({q[30:0], e}, 32'h1);
         apb(1'b1, OFS_CTRL, {30'h0, 1'b1, p == 2});
         apb(1'b0, OFS_CTRL, 32'h0);
         chk(q, {30'h0, 1'b1, p == 2});
         if (p == 0) for (n = 0; n < 32; n++) acc({8'h0a, 18'h0, 5'(n), 1'b0}, 1'b1, 1'b0);
         for (n = 0; n < 40; n++) begin
            t = lfsr(rv);
            acc({8'h0a, 2'h0, t[9], t[15:10], 9'h0, t[4:0], !t[7] & (w8 | t[6])}, t[8], t[7]);
         end
         apb(1'b0, OFS_COUNT, 32'h0);
         chk(q, p == 0 ? 32'd72 : 32'd40);
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(q, 32'h0);
      end
      close_out();
   end
endmodule : generic_host_bus_glue_test
